// ### hdl/mrp_pkg.sv
// Package: constants and types for the memory region protection unit
package mrp_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned MRP_REGIONS = 8;
  localparam int unsigned MRP_IDX_W = 3;

  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] MRP_OFF_CTRL = 8'h00;
  localparam logic [7:0] MRP_OFF_COUNT = 8'h04;
  localparam logic [7:0] MRP_OFF_SELECT = 8'h08;
  localparam logic [7:0] MRP_OFF_BASE = 8'h0C;
  localparam logic [7:0] MRP_OFF_ATTR = 8'h10;
  localparam logic [7:0] MRP_OFF_STATUS = 8'h14;
  localparam logic [7:0] MRP_OFF_ADDR = 8'h18;

  // ==========================================================
  // Global control bits
  localparam int unsigned MRP_CTRL_ON_BIT = 0;
  localparam int unsigned MRP_CTRL_HFNMI_BIT = 1;
  localparam int unsigned MRP_CTRL_PRIVDEF_BIT = 2;

  // ==========================================================
  // Attribute word field positions
  localparam int unsigned MRP_ATTR_ON_BIT = 0;
  localparam int unsigned MRP_ATTR_SIZE_LSB = 1;
  localparam int unsigned MRP_ATTR_SUB_LSB = 8;
  localparam int unsigned MRP_ATTR_PERM_LSB = 24;
  localparam int unsigned MRP_ATTR_XN_BIT = 28;

  // ==========================================================
  // Size codes: size = 2^(code+1); 32 B is code 4, 4 GB is code 31
  localparam logic [4:0] MRP_SIZE_MIN = 5'h04;
  localparam logic [4:0] MRP_SIZE_SUB_MIN = 5'h07;

  // Read/write permission codes
  localparam logic [2:0] MRP_PERM_NO_NO = 3'h0;
  localparam logic [2:0] MRP_PERM_RW_NO = 3'h1;
  localparam logic [2:0] MRP_PERM_RW_RO = 3'h2;
  localparam logic [2:0] MRP_PERM_RW_RW = 3'h3;
  localparam logic [2:0] MRP_PERM_RO_NO = 3'h5;
  localparam logic [2:0] MRP_PERM_RO_RO = 3'h6;

  // ==========================================================
  // Reset values
  localparam logic [2:0] MRP_CTRL_RST = 3'h0;
  localparam logic [31:0] MRP_WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic execute_forbidden;
    logic [2:0] rw_permission_code;
    logic [7:0] subregion_off_bits;
    logic [4:0] region_size_code;
    logic region_on_flag;
  } mrp_attr_t;

  typedef struct packed {
    logic [31:0] base;
    mrp_attr_t attr;
  } mrp_region_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic fetch;
    logic write;
    logic priv;
    logic fault_handler;
  } mrp_access_t;

endpackage

// ### hdl/mrp_region_match.sv
// Region match and permission check for one region
module mrp_region_match
  import mrp_pkg::*;
(
  input wire mrp_pkg::mrp_region_t region_i,
  input wire mrp_pkg::mrp_access_t access_i,
  output logic hit_o,
  output logic allow_o
);
  import mrp_pkg::*;

  logic [31:0] mask;
  logic [2:0] sub_idx;
  logic sub_off;
  logic rd_ok;
  logic wr_ok;
  logic [2:0] perm;

  always_comb
  begin
    mask = 32'hFFFF_FFFF << (region_i.attr.region_size_code + 5'h01);
    if (region_i.attr.region_size_code == 5'h1F)
    begin
      mask = 32'h0000_0000;
    end
    sub_idx = 3'(access_i.addr >> (region_i.attr.region_size_code - 5'h02));
    // Small regions ignore sub-region bits: a sub-region would be under 32 B
    sub_off = (region_i.attr.region_size_code >= MRP_SIZE_SUB_MIN) &&
              region_i.attr.subregion_off_bits[sub_idx];
    hit_o = region_i.attr.region_on_flag &&
            ((access_i.addr & mask) == (region_i.base & mask)) && !sub_off;
    perm = region_i.attr.rw_permission_code;
    unique case (perm)
      MRP_PERM_RW_NO:
      begin
        rd_ok = access_i.priv;
        wr_ok = access_i.priv;
      end
      MRP_PERM_RW_RO:
      begin
        rd_ok = 1'b1;
        wr_ok = access_i.priv;
      end
      MRP_PERM_RW_RW:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      MRP_PERM_RO_NO:
      begin
        rd_ok = access_i.priv;
        wr_ok = 1'b0;
      end
      MRP_PERM_RO_RO:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b0;
      end
      default:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
    // separate privileged and user checks; execute bit
    if (access_i.fetch)
    begin
      allow_o = rd_ok && !region_i.attr.execute_forbidden;
    end
    else
    begin
      allow_o = access_i.write ? wr_ok : rd_ok;
    end
  end

endmodule

// ### hdl/mrp_unit.sv
// Top: memory region protection unit with register port and access checker
//
// Overview of operation
// - Count register reports the number of implemented regions.
// - Clearing a region's enable keeps its settings for later re-enable.
// - Enabled regions apply permissions; violations raise a fault.
// - Base and attributes read back in the written encoding.
// - Attribute readback carries the enable; writing it back restores it.
// - Size code covers 32 bytes to 4 gigabytes, one per region.
// - One execute bit per region; set means fetches fault.
// - Read/write checked separately for privileged and user accesses.
// - Each region splits into eight sub-regions with own disable bits.
// - Sub-region disables apply only to regions of 256 bytes or more.
// - Address in a disabled sub-region is not matched by that region.
// - Enable bit is written together with the other attributes.
// - At most eight independently programmable regions.
// - Globally disabled unit uses default map and raises no faults.
// - Optional privileged fall-back to default map on no match.
// - Optional protection inside hard fault and non-maskable handlers.
module mrp_unit
  import mrp_pkg::*;
#(
  parameter int unsigned REGIONS = MRP_REGIONS
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire mrp_pkg::mrp_access_t access_i,
  output logic fault_o,
  output logic done_o
);
  import mrp_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    mrp_region_t [MRP_REGIONS-1:0] rgn;
    logic [2:0] ctrl;
    logic [7:0] sel;
    logic [31:0] rdata;
    logic fault;
    logic done;
    logic sticky;
    logic [31:0] fault_addr;
  } mrp_state_t;

  mrp_state_t s_q;
  mrp_state_t s_d;

  // ==========================================================
  // Region checkers
  logic [MRP_REGIONS-1:0] hit;
  logic [MRP_REGIONS-1:0] allow;

  generate
    for (genvar g = 0; g < MRP_REGIONS; g++)
    begin : g_rgn
      mrp_region_match u_match (
        .region_i(s_q.rgn[g]),
        .access_i(access_i),
        .hit_o(hit[g]),
        .allow_o(allow[g])
      );
    end
  endgenerate

  // ==========================================================
  // Priority select and fault decision
  logic any_hit;
  logic win_allow;
  logic bypass;
  logic viol;
  logic sel_ok;
  logic [7:0] region_count;

  assign region_count = 8'(REGIONS);
  assign sel_ok = s_q.sel < region_count;

  always_comb
  begin
    any_hit = 1'b0;
    win_allow = 1'b0;
    // Later regions overwrite earlier ones, so the highest index wins
    for (int i = 0; i < MRP_REGIONS; i++)
    begin
      if (hit[i] && (i < REGIONS))
      begin
        any_hit = 1'b1;
        win_allow = allow[i];
      end
    end
    bypass = !s_q.ctrl[MRP_CTRL_ON_BIT] ||
             (access_i.fault_handler && !s_q.ctrl[MRP_CTRL_HFNMI_BIT]);
    if (any_hit)
    begin
      viol = !win_allow;
    end
    else
    begin
      viol = !(access_i.priv && s_q.ctrl[MRP_CTRL_PRIVDEF_BIT]);
    end
    viol = viol && !bypass && access_i.valid;
  end

  // ==========================================================
  // Register port and next state
  logic [MRP_IDX_W-1:0] idx;
  assign idx = s_q.sel[MRP_IDX_W-1:0];

  always_comb
  begin
    s_d = s_q;
    s_d.fault = viol;
    s_d.done = access_i.valid;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        MRP_OFF_CTRL: s_d.ctrl = reg_wdata_i[2:0];
        MRP_OFF_SELECT: s_d.sel = reg_wdata_i[7:0];
        MRP_OFF_BASE:
        begin
          if (sel_ok)
          begin
            s_d.rgn[idx].base = reg_wdata_i;
          end
        end
        MRP_OFF_ATTR:
        begin
          if (sel_ok)
          begin
            s_d.rgn[idx].attr.region_on_flag = reg_wdata_i[MRP_ATTR_ON_BIT];
            s_d.rgn[idx].attr.region_size_code =
              reg_wdata_i[MRP_ATTR_SIZE_LSB +: 5] < MRP_SIZE_MIN ? MRP_SIZE_MIN
              : reg_wdata_i[MRP_ATTR_SIZE_LSB +: 5];
            s_d.rgn[idx].attr.subregion_off_bits = reg_wdata_i[MRP_ATTR_SUB_LSB +: 8];
            s_d.rgn[idx].attr.rw_permission_code = reg_wdata_i[MRP_ATTR_PERM_LSB +: 3];
            s_d.rgn[idx].attr.execute_forbidden = reg_wdata_i[MRP_ATTR_XN_BIT];
          end
        end
        MRP_OFF_STATUS:
        begin
          if (reg_wdata_i[0])
          begin
            s_d.sticky = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // A new fault beats a clear in the same cycle
    if (viol)
    begin
      s_d.sticky = 1'b1;
      s_d.fault_addr = access_i.addr;
    end
    s_d.rdata = MRP_WORD_RST;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        MRP_OFF_CTRL: s_d.rdata = {29'h0000_0000, s_q.ctrl};
        MRP_OFF_COUNT: s_d.rdata = {24'h00_0000, region_count};
        MRP_OFF_SELECT: s_d.rdata = {24'h00_0000, s_q.sel};
        MRP_OFF_BASE: s_d.rdata = sel_ok ? s_q.rgn[idx].base : MRP_WORD_RST;
        MRP_OFF_ATTR:
        begin
          if (sel_ok)
          begin
            s_d.rdata[MRP_ATTR_ON_BIT] = s_q.rgn[idx].attr.region_on_flag;
            s_d.rdata[MRP_ATTR_SIZE_LSB +: 5] = s_q.rgn[idx].attr.region_size_code;
            s_d.rdata[MRP_ATTR_SUB_LSB +: 8] = s_q.rgn[idx].attr.subregion_off_bits;
            s_d.rdata[MRP_ATTR_PERM_LSB +: 3] = s_q.rgn[idx].attr.rw_permission_code;
            s_d.rdata[MRP_ATTR_XN_BIT] = s_q.rgn[idx].attr.execute_forbidden;
          end
        end
        MRP_OFF_STATUS: s_d.rdata = {31'h0000_0000, s_q.sticky};
        MRP_OFF_ADDR: s_d.rdata = s_q.fault_addr;
        default: s_d.rdata = MRP_WORD_RST;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign fault_o = s_q.fault;
  assign done_o = s_q.done;

  // ==========================================================
  // Assertions
  off_no_fault_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !s_q.ctrl[MRP_CTRL_ON_BIT] && !reg_wr_i |=> !fault_o)
    else $error("fault raised while unit disabled");

  count_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == MRP_OFF_COUNT |=> reg_rdata_o == 32'(REGIONS))
    else $error("region count readback wrong");

  attr_roundtrip_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == MRP_OFF_ATTR && sel_ok ##1
    reg_rd_i && reg_addr_i == MRP_OFF_ATTR && !reg_wr_i
    |=> reg_rdata_o[MRP_ATTR_ON_BIT] == $past(reg_wdata_i[MRP_ATTR_ON_BIT], 2))
    else $error("enable not preserved in attribute readback");

  base_roundtrip_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == MRP_OFF_BASE && sel_ok ##1
    reg_rd_i && reg_addr_i == MRP_OFF_BASE |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("base readback differs");

  hfnmi_bypass_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    access_i.valid && access_i.fault_handler && !s_q.ctrl[MRP_CTRL_HFNMI_BIT]
    |=> !fault_o)
    else $error("fault inside handler without protection option");

  nohit_user_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    access_i.valid && !access_i.priv && !any_hit && !bypass |=> fault_o)
    else $error("unmatched user access did not fault");

  bad_sel_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == MRP_OFF_BASE && !sel_ok |=> $stable(s_q.rgn))
    else $error("write to absent region took effect");

  done_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    access_i.valid && any_hit && !win_allow && !bypass |=> fault_o && done_o)
    else $error("violation not reported");

endmodule

// ### dv/mrp_core_model.sv
// Core model: issues one access at a time to the protection unit
module mrp_core_model
(
  input wire logic clock_i,
  input wire logic fault_i,
  input wire logic done_i,
  output mrp_pkg::mrp_access_t access_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mrp_pkg::*;

  initial
  begin
    access_o = '0;
  end

  // ==========================================================
  // Access cycle
  // Kind is {fetch, write, priv, handler}
  // Released address shows its inverse, so a stale value never passes for a live one
  task automatic issue(input logic [31:0] a, input logic [3:0] k, output logic f,
                       output logic d);
    @(posedge clock_i);
    access_o <= '{1'b1, a, k[3], k[2], k[1], k[0]};
    @(posedge clock_i);
    access_o.valid <= 1'b0;
    access_o.addr <= ~a;
    #1;
    f = fault_i;
    d = done_i;
  endtask
endmodule

// ### dv/memory_region_protection_bench.sv
// Testbench: register port tasks and access scenarios for the protection unit
module memory_region_protection_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mrp_pkg::*;

  // ==========================================================
  // Signals
  // Fewer regions than the maximum, so out-of-range selects can be reached
  localparam int unsigned NREG = 6;
  localparam logic [3:0] UR = 4'h0;
  localparam logic [3:0] UW = 4'h4;
  localparam logic [3:0] PR = 4'h2;
  localparam logic [3:0] PW = 4'h6;
  localparam logic [3:0] PH = 4'h3;
  localparam logic [3:0] HW = 4'h5;
  localparam logic [3:0] FX = 4'h8;
  localparam logic [2:0] PERMS [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  // Expected faults for PR, PW, UR, UW in that bit order
  localparam logic [3:0] FTAB [6] = '{4'hF, 4'h3, 4'h1, 4'h0, 4'h7, 4'h5};
  localparam logic [3:0] KINDS [4] = '{PR, PW, UR, UW};
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  mrp_access_t access_i;
  logic fault_o;
  logic done_o;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic f;
  logic d;

  mrp_unit #(.REGIONS(NREG)) mrp_unit_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .access_i(access_i), .fault_o(fault_o), .done_o(done_o));
  mrp_core_model mrp_core_model_inst (
    .clock_i(clock_i), .fault_i(fault_o), .done_i(done_o), .access_o(access_i));

  initial
  begin
    forever #20 clock_i = ~clock_i;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    check(what, reg_rdata_o, exp);
  endtask

  // Read straight after the write, so the readback path is seen with no idle cycle
  task automatic wr_rd(input string what, input logic [7:0] a, input logic [31:0] v,
                       input logic [31:0] exp);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    check(what, reg_rdata_o, exp);
  endtask

  task automatic acc(input logic [31:0] a, input logic [3:0] k, input logic exp);
    mrp_core_model_inst.issue(a, k, f, d);
    check("done", {31'h0, d}, 32'h1);
    check("fault", {31'h0, f}, {31'h0, exp});
  endtask

  // Regions are only rewritten while disabled, with size-aligned bases
  task automatic set_rgn(input logic [31:0] n, input logic [31:0] b, input logic [31:0] at);
    wr(MRP_OFF_SELECT, n);
    wr(MRP_OFF_BASE, b);
    wr(MRP_OFF_ATTR, at);
  endtask

  function automatic logic [31:0] attr(input logic xn, input logic [2:0] p,
                                       input logic [7:0] s, input logic [4:0] c,
                                       input logic on);
    return {3'h0, xn, 1'b0, p, 8'h00, s, 2'b00, c, on};
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #300us;
    n_errors++;
    print_verdict();
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk_reg("count", MRP_OFF_COUNT, 32'(NREG));
    chk_reg("unmapped", 8'h1C, 32'h0);
    acc(32'h100, UW, 1'b0);
    $display("test reset done");
    set_rgn(0, 32'h0, attr(1'b0, MRP_PERM_RW_RW, 8'h00, 5'h0C, 1'b1));
    set_rgn(1, 32'h1000, attr(1'b1, MRP_PERM_RO_RO, 8'h02, 5'h07, 1'b1));
    chk_reg("base", MRP_OFF_BASE, 32'h1000);
    chk_reg("attr", MRP_OFF_ATTR, attr(1'b1, MRP_PERM_RO_RO, 8'h02, 5'h07, 1'b1));
    wr(MRP_OFF_CTRL, 32'h1);
    acc(32'h100, UW, 1'b0);
    acc(32'h100, FX, 1'b0);
    acc(32'h1000, UR, 1'b0);
    acc(32'h1000, UW, 1'b1);
    acc(32'h1000, FX, 1'b1);
    acc(32'h1020, UW, 1'b0);
    acc(32'h3000, PR, 1'b1);
    acc(32'h3000, PH, 1'b0);
    $display("test regions done");
    wr(MRP_OFF_ATTR, attr(1'b1, MRP_PERM_RO_RO, 8'h02, 5'h07, 1'b0));
    acc(32'h1000, UW, 1'b0);
    chk_reg("base kept", MRP_OFF_BASE, 32'h1000);
    chk_reg("attr off", MRP_OFF_ATTR, attr(1'b1, MRP_PERM_RO_RO, 8'h02, 5'h07, 1'b0));
    wr(MRP_OFF_ATTR, attr(1'b1, MRP_PERM_RO_RO, 8'h02, 5'h07, 1'b1));
    acc(32'h1000, UW, 1'b1);
    $display("test enable done");
    wr(MRP_OFF_CTRL, 32'h7);
    acc(32'h3000, PR, 1'b0);
    acc(32'h3000, UR, 1'b1);
    acc(32'h1000, HW, 1'b1);
    set_rgn(2, 32'h4000, attr(1'b0, MRP_PERM_NO_NO, 8'hFF, 5'h05, 1'b1));
    acc(32'h4000, PR, 1'b1);
    set_rgn(3, 32'h5000, attr(1'b0, MRP_PERM_NO_NO, 8'hFF, 5'h07, 1'b1));
    acc(32'h5000, PR, 1'b0);
    $display("test options done");
    for (int i = 0; i < 6; i++)
    begin
      set_rgn(4, 32'h6000, attr(1'b0, PERMS[i], 8'h00, 5'h07, 1'b1));
      for (int j = 0; j < 4; j++)
        acc(32'h6000, KINDS[j], FTAB[i][3 - j]);
      wr(MRP_OFF_ATTR, 32'h0);
    end
    $display("test permissions done");
    wr(MRP_OFF_SELECT, 32'h5);
    wr_rd("base rewrite", MRP_OFF_BASE, 32'h0000_A000, 32'h0000_A000);
    for (int c = 4; c < 32; c++)
    begin
      wr_rd("size", MRP_OFF_ATTR, attr(1'b0, MRP_PERM_RW_RW, 8'h00, 5'(c), 1'b0),
            attr(1'b0, MRP_PERM_RW_RW, 8'h00, 5'(c), 1'b0));
    end
    $display("test sizes done");
    set_rgn(7, 32'h8000, attr(1'b0, MRP_PERM_NO_NO, 8'h00, 5'h07, 1'b1));
    chk_reg("attr beyond count", MRP_OFF_ATTR, 32'h0);
    acc(32'h8000, PR, 1'b0);
    wr(MRP_OFF_SELECT, 32'h1);
    chk_reg("base region 1", MRP_OFF_BASE, 32'h1000);
    chk_reg("select", MRP_OFF_SELECT, 32'h1);
    chk_reg("ctrl", MRP_OFF_CTRL, 32'h7);
    chk_reg("fault addr", MRP_OFF_ADDR, 32'h6000);
    chk_reg("sticky", MRP_OFF_STATUS, 32'h1);
    wr(MRP_OFF_STATUS, 32'h1);
    chk_reg("sticky clear", MRP_OFF_STATUS, 32'h0);
    $display("test range done");
    print_verdict();
  end
endmodule
